// *** design/ddsl_pkg.sv ***
// Purpose: constants and carrier types for the dual converter serial load
// Assumes: one clock, synchronous active-high reset
// Notes:   word layout is fixed by the converter's shift word
//
// What this block does
// - the 16-bit word is mode, chan1 enable, chan0 enable, spare, code.
// - mode bit 0 loads both channels on a 0-to-1 strobe edge.
// - mode bit 1 lets the enable bits pick the channels on load.
// - in software mode channel 1 loads only if its enable is 1.
// - in software mode channel 0 loads only if its enable is 1.
// - codes change only on a 0-to-1 load strobe edge, never on shifts.
// - codes are 12-bit straight binary, 000h zero to fffh full scale.
package ddsl_pkg;
    localparam int WORD_W      = 16;
    localparam int CODE_W      = 12;
    localparam int MODE_BIT    = 15;
    localparam int CHAN1_BIT   = 14;
    localparam int CHAN0_BIT   = 13;
    localparam int UNUSED_BIT  = 12;
    localparam logic [7:0] TARGET_CONVERTER = 8'h01;
    localparam int STROBE_BIT  = 3;
    localparam logic [7:0] TARGET_MASK    = 8'hf7;
    localparam logic [7:0] TARGET_RESET   = 8'h00;
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [15:0] WORD_RESET     = 16'h0000;

    typedef struct packed {
        logic [CODE_W-1:0] chan1;
        logic [CODE_W-1:0] chan0;
    } ddsl_codes_t;
endpackage

// *** design/ddsl_shift_word.sv ***
// Purpose: serial shift word, one bit per data-port write
// Assumes: write strobe is a one-cycle pulse on clock_i
// Notes:   bits enter at the lsb, so the first bit ends up at the top
`timescale 1ns/1ps
module ddsl_shift_word #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    // shift port
    input  wire logic             shift_en_i,
    input  wire logic             bit_i,
    output logic [WIDTH-1:0]      word_o
);
    if (WIDTH < 2) begin : g_width_check
        $error("ddsl_shift_word: WIDTH too small");
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            word_o <= '0;
        end else if (shift_en_i) begin
            word_o <= {word_o[WIDTH-2:0], bit_i};
        end
    end
endmodule

// *** design/ddsl_top.sv ***
// Purpose: dual 12-bit converter load logic behind a serial bit port
// Assumes: host writes arrive as one-cycle strobes on clock_i
// Notes:   the load strobe is a level; only its rising edge loads
`timescale 1ns/1ps
module ddsl_top
    import ddsl_pkg::*;
(
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    // serial data port write
    input  wire logic                 serial_write_bit_port_we_i,
    input  wire logic [7:0]           serial_write_bit_port_i,
    // serial target select register write
    input  wire logic                 serial_target_select_we_i,
    input  wire logic [7:0]           serial_target_select_i,
    // converter codes and load strobe
    output ddsl_pkg::ddsl_codes_t     codes_o,
    output logic                      load_strobe_o
);
    import ddsl_pkg::*;

    logic [7:0]          target_q;
    logic                strobe_q;
    logic                strobe_prev_q;
    logic [WORD_W-1:0]   dac_load_shift_word;
    logic                load_edge;
    logic                shift_en;
    logic                load_mode_select;
    logic                chan1_en;
    logic                chan0_en;
    logic [CODE_W-1:0]   output_code;
    logic [CODE_W-1:0]   chan1_q;
    logic [CODE_W-1:0]   chan0_q;

    // one load decision for both channels
    function automatic logic chan_takes(input logic mode_bit,
                                        input logic en_bit);
        chan_takes = !mode_bit || en_bit;
    endfunction

    // target bits of a select byte, strobe masked off
    function automatic logic [7:0] target_of(input logic [7:0] sel);
        target_of = sel & TARGET_MASK;
    endfunction

    // bits shift only when converter is target
    assign shift_en = serial_write_bit_port_we_i &&
                      (target_q == TARGET_CONVERTER);

    ddsl_shift_word #(
        .WIDTH(WORD_W)
    ) u_shift (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .shift_en_i (shift_en),
        .bit_i      (serial_write_bit_port_i[0]),
        .word_o     (dac_load_shift_word)
    );

    assign load_mode_select = dac_load_shift_word[MODE_BIT];
    assign chan1_en         = dac_load_shift_word[CHAN1_BIT];
    assign chan0_en         = dac_load_shift_word[CHAN0_BIT];
    assign output_code      = dac_load_shift_word[CODE_W-1:0];

    // target held apart from the strobe bit
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            target_q <= TARGET_RESET;
        end else if (serial_target_select_we_i) begin
            target_q <= target_of(serial_target_select_i);
        end
    end

    // load strobe is select bit 3, a level
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            strobe_q <= 1'b0;
        end else if (serial_target_select_we_i) begin
            strobe_q <= serial_target_select_i[STROBE_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            strobe_prev_q <= 1'b0;
        end else begin
            strobe_prev_q <= strobe_q;
        end
    end

    assign load_edge = strobe_q && !strobe_prev_q;

    // channel 1 takes the straight binary code
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan1_q <= CODE_RESET;
        end else if (load_edge &&
                     chan_takes(load_mode_select, chan1_en)) begin
            chan1_q <= output_code;
        end
    end

    // channel 0 takes the same code, in software mode only on its own enable
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan0_q <= CODE_RESET;
        end else if (load_edge &&
                     chan_takes(load_mode_select, chan0_en)) begin
            chan0_q <= output_code;
        end
    end

    // codes_o changes only on a strobe rising edge, taking the word as it stands; load_strobe_o is the strobe level
    assign codes_o       = '{chan1: chan1_q, chan0: chan0_q};
    assign load_strobe_o = strobe_q;

    sequence s_load_hw;
        !strobe_q ##1 (strobe_q && !load_mode_select);
    endsequence

    sequence s_load_sw;
        !strobe_q ##1 (strobe_q && load_mode_select);
    endsequence

    sequence s_strobe_held;
        strobe_q ##1 strobe_q;
    endsequence

    sequence s_sel_raise;
        serial_target_select_we_i &&
        serial_target_select_i[STROBE_BIT] && !strobe_q;
    endsequence

    a_hold_no_edge: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !$rose(strobe_q) |=> $stable(codes_o))
        else $error("output changed without load edge");

    a_hw_both: assert property (
        @(posedge clock_i) disable iff (rst_i)
        s_load_hw |=>
        codes_o.chan0 == $past(output_code) &&
        codes_o.chan1 == $past(output_code))
        else $error("hardware mode did not load both");

    a_sw_chan1: assert property (
        @(posedge clock_i) disable iff (rst_i)
        s_load_sw |=>
        codes_o.chan1 == ($past(chan1_en) ? $past(output_code)
                                          : $past(codes_o.chan1)))
        else $error("channel 1 load wrong");

    a_sw_chan0: assert property (
        @(posedge clock_i) disable iff (rst_i)
        s_load_sw |=>
        codes_o.chan0 == ($past(chan0_en) ? $past(output_code)
                                          : $past(codes_o.chan0)))
        else $error("channel 0 load wrong");

    a_one_load: assert property (
        @(posedge clock_i) disable iff (rst_i)
        s_strobe_held |=> $stable(codes_o))
        else $error("held strobe loaded twice");

    // shift moves word up by one
    a_shift_step: assert property (
        @(posedge clock_i) disable iff (rst_i)
        shift_en |=> dac_load_shift_word ==
        {$past(dac_load_shift_word[WORD_W-2:0]),
         $past(serial_write_bit_port_i[0])})
        else $error("shift step wrong");

    a_refuse_shift: assert property (
        @(posedge clock_i) disable iff (rst_i)
        serial_write_bit_port_we_i &&
        target_q != TARGET_CONVERTER |=>
        $stable(dac_load_shift_word))
        else $error("shift taken for another target");

    a_strobe_follow: assert property (
        @(posedge clock_i) disable iff (rst_i)
        serial_target_select_we_i |=>
        load_strobe_o == $past(serial_target_select_i[STROBE_BIT]))
        else $error("load strobe does not follow select write");

    a_strobe_keep: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !serial_target_select_we_i |=> $stable(load_strobe_o))
        else $error("load strobe changed without select write");

    a_target_keep: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !serial_target_select_we_i |=> $stable(target_q))
        else $error("target changed without select write");

    a_reset_clear: assert property (
        @(posedge clock_i)
        rst_i |=> codes_o == '0 && !load_strobe_o)
        else $error("reset did not clear outputs");

    a_word_cleared: assert property (
        @(posedge clock_i)
        rst_i |=> dac_load_shift_word == WORD_RESET)
        else $error("reset did not clear shift word");

    a_load_latency: assert property (
        @(posedge clock_i) disable iff (rst_i)
        s_sel_raise ##1 !load_mode_select |=>
        codes_o.chan1 == $past(output_code) &&
        codes_o.chan0 == $past(output_code))
        else $error("load did not land two edges after write");
endmodule

// *** tb/ddsl_host.sv ***
// Purpose: host model for bit and select writes
// Assumes: one write every two cycles
// Notes:   idle bytes flip so stale data cannot pass
`timescale 1ns/1ps
module ddsl_host (
    // clock
    input  wire logic  clock_i,
    // host writes
    output logic       dwe_o,
    output logic [7:0] dat_o,
    output logic       swe_o,
    output logic [7:0] sel_o
);
    initial begin
        {dwe_o, swe_o, dat_o, sel_o} = '0;
    end
    task automatic wr(input logic s, input logic [7:0] b);
        @(posedge clock_i);
        #1;
        swe_o = s;
        dwe_o = !s;
        if (s) sel_o = b;
        else dat_o = b;
        @(posedge clock_i);
        #1;
        {dwe_o, swe_o} = 2'b00;
        dat_o = ~dat_o;
        sel_o = ~sel_o;
    endtask
    task automatic put_word(input logic [15:0] v);
        for (int i = 15; i >= 0; i--) wr(1'b0, {7'h00, v[i]});
    endtask
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the load logic
// Assumes: host model drives every write
// Notes:   codes queued at load, compared after it
`timescale 1ns/1ps
module testbench;
    import ddsl_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        dwe, swe, load_strobe_o;
    logic [7:0]  dat, sel;
    logic [15:0] w, w2;
    ddsl_codes_t codes_o, cur, q[$];
    int          err_count = 0, num_checks = 0, cyc = 0;
    int          seed = 32'h8a7b;
    logic [3:0]  top [6] = '{4'h0, 4'h6, 4'hc, 4'ha, 4'he, 4'h8};
    always #50 clock_i = ~clock_i;
    ddsl_host HOST (.clock_i(clock_i), .dwe_o(dwe), .dat_o(dat),
        .swe_o(swe), .sel_o(sel));
    ddsl_top DUT (.clock_i(clock_i), .rst_i(rst_i),
        .serial_write_bit_port_we_i(dwe), .serial_write_bit_port_i(dat),
        .serial_target_select_we_i(swe), .serial_target_select_i(sel),
        .codes_o(codes_o), .load_strobe_o(load_strobe_o));
    task automatic check(string n, logic [23:0] s, logic [23:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    function automatic ddsl_codes_t nxt(ddsl_codes_t c, logic [15:0] v);
        nxt = c;
        if (!v[MODE_BIT] || v[CHAN1_BIT]) nxt.chan1 = v[CODE_W-1:0];
        if (!v[MODE_BIT] || v[CHAN0_BIT]) nxt.chan0 = v[CODE_W-1:0];
    endfunction
    task automatic ld(logic [7:0] s, logic [15:0] v);
        cur = nxt(cur, v);
        q.push_back(cur);
        HOST.wr(1'b1, s);
        HOST.wr(1'b1, s & 8'hf7);
        check("strobe low", 24'(load_strobe_o), '0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            err_count++;
            give_verdict();
        end
    end
    always @(posedge load_strobe_o) begin
        @(posedge clock_i);
        #2;
        check("codes", codes_o, q.size() ? q.pop_front() : 'x);
        check("strobe high", 24'(load_strobe_o), 24'h1);
    end
    initial begin
        cur = '0;
        repeat (3) @(posedge clock_i);
        #1 rst_i = 1'b0;
        check("reset", codes_o, '0);
        HOST.wr(1'b1, TARGET_CONVERTER);
        for (int i = 0; i < 6; i++) begin
            w = {top[i], 12'($random(seed))};
            if (i < 2) w[11:0] = {12{~i[0]}};
            HOST.put_word(w);
            check("hold", codes_o, cur);
            ld(8'h09, w);
            $display("load case %0d done", i);
        end
        // held strobe must not load a second time
        w2 = {4'ha, 12'($random(seed))};
        q.push_back(cur);
        HOST.wr(1'b1, 8'h09);
        HOST.put_word(w2);
        HOST.wr(1'b1, 8'h09);
        HOST.wr(1'b1, 8'h01);
        check("held", codes_o, cur);
        ld(8'h09, w2);
        $display("held strobe test done");
        // shifting with target 00h must be ignored
        ld(8'h08, w2);
        HOST.put_word(~w2);
        HOST.wr(1'b1, TARGET_CONVERTER);
        ld(8'h09, w2);
        $display("refused shift test done");
        repeat (3) @(posedge clock_i);
        check("queue", 24'(q.size()), '0);
        give_verdict();
    end
endmodule
